/* src/uotg_consts.vh */
// Purpose: constants for the dual-role session and role control block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: offsets are local choices, data in the low byte
`ifndef UOTG_CONSTS_VH
`define UOTG_CONSTS_VH
`define UOTG_ADDR_W 6
`define UOTG_OFF_OTGSTAT 6'h00
`define UOTG_OFF_OTGCON 6'h04
`define UOTG_OFF_PWRC 6'h08
`define UOTG_OFF_OTGIR 6'h0C
`define UOTG_OFF_LINKIR 6'h10
`define UOTG_OFF_CNFG2 6'h14
`define UOTG_OFF_BDTP 6'h18
`define UOTG_OFF_FRML 6'h1C
`define UOTG_OFF_FRMH 6'h20
`define UOTG_OFF_UCON 6'h24
`define UOTG_BIT_ID 7
`define UOTG_BIT_LINE_STABLE_INDICATOR 5
`define UOTG_BIT_SESSION_VALID_INDICATOR 3
`define UOTG_BIT_SESSION_END_INDICATOR 2
`define UOTG_BIT_A_SIDE_SUPPLY_VALID 0
`define UOTG_BIT_DPPU 7
`define UOTG_BIT_DMPU 6
`define UOTG_BIT_DPPD 5
`define UOTG_BIT_DMPD 4
`define UOTG_BIT_VBON 3
`define UOTG_BIT_DUAL_ROLE_FEATURES_ENABLE 2
`define UOTG_BIT_VBCHG 1
`define UOTG_BIT_VBDIS 0
`define UOTG_BIT_IR_ATTACH 6
`define UOTG_BIT_IR_RST 0
`define UOTG_BIT_PULSE 4
`define UOTG_BIT_HOST_ROLE_ENABLE 3
`define UOTG_BIT_PERIPHERAL_ROLE_ENABLE 0
`define UOTG_BIT_SUSP 1
`define UOTG_BIT_PWR 0
`define UOTG_BIT_SLPGRD 4
`define UOTG_BIT_ACTPND 7
`define UOTG_STABLE_US 1000
`define UOTG_CLK_MHZ 125
`define UOTG_STABLE_CYC (`UOTG_STABLE_US * `UOTG_CLK_MHZ)
`endif

/* src/uotg_session_ctrl.v */
// Purpose: dual-role session and role control registers over apb
// Assumes: 125 MHz clock, comparator and line inputs asynchronous to it
// Notes: zero wait state apb, unmapped reads return zero, pslverr low
// Functional notes
// R1: software checks vbus low, lines low 2ms
// R2: session end flag set on vbus drop
// R3: self-powered b-device clears both pull-ups
// R4: software pulses d+ pull-up 5-10 ms
// R5: software pulses vbus via config bit
// R6: b-device ignores vbus, reconnects after valid
// R7: a-device restores vbus on srp
// R8: a-device ends srp with bus reset
// R9: negotiate only full speed, once enabled; code still drives the d- pull-up from otgcon bit 6 when dual-role is enabled
// R10: b-device requests host by disconnecting
// R11: a-device yields host via d+ pull-up
// R12: new b-host drives reset first
// R13: b-host returns, a-device drops pull-up
// R14: a-device resumes host on attach
// R15: upper byte reads zero everywhere
// R16: descriptor page 8 bits, bit0 zero
// R17: 11-bit frame count, low/high registers
// R18: plug-type bit 7 status
// R19: line-stable bit after 1 ms unchanged
// R20: session, end, a-valid status bits
// R21: dual-role enable selects pull control source
// R22: vbus power, charge, discharge controls
// R23: suspend gates clock, enable powers module
// R24: synchronised inputs, edges set flags
`timescale 1ns/1ps
`include "uotg_consts.vh"
module uotg_session_ctrl #(
  parameter STABLE_CYC = `UOTG_STABLE_CYC
) (
  input wire clock_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`UOTG_ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire id_pin_in,
  input wire sess_vld_cmp_in,
  input wire sess_end_cmp_in,
  input wire vbus_vld_cmp_in,
  input wire se0_in,
  input wire jstate_in,
  input wire frame_tick_in,
  input wire activity_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  output reg dplus_pullup_out,
  output reg dminus_pullup_out,
  output reg dplus_pulldown_out,
  output reg dminus_pulldown_out,
  output reg vbus_power_on_out,
  output reg vbus_charge_out,
  output reg vbus_discharge_out,
  output reg vbus_pulse_out,
  output reg clock_gate_out,
  output reg xcvr_low_power_out,
  output reg module_enable_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {jstate_in, se0_in, vbus_vld_cmp_in, sess_end_cmp_in,
                    sess_vld_cmp_in, id_pin_in}; // see R24
      sync2_reg <= sync1_reg;
    end
  end
  wire id_s = sync2_reg[0];
  wire session_valid_indicator_s = sync2_reg[1];
  wire session_end_indicator_s = sync2_reg[2];
  wire a_side_supply_valid_s = sync2_reg[3];
  wire [1:0] line_s = sync2_reg[5:4];

  // ----------------------------------------
  // line stability timer
  // ----------------------------------------
  reg [1:0] line_prev_reg;
  reg [31:0] stable_cnt_reg;
  reg stable_reg;
  reg session_valid_indicator_prev_reg;
  reg session_end_indicator_prev_reg;
  reg [1:0] prime_reg;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prime_reg <= 2'h0;
      line_prev_reg <= 2'h0;
      stable_cnt_reg <= 32'h0;
      stable_reg <= 1'b0;
      session_valid_indicator_prev_reg <= 1'b0;
      session_end_indicator_prev_reg <= 1'b0;
    end else begin
      line_prev_reg <= line_s;
      // edges count only once both stages and the last value hold real samples
      if (prime_reg != 2'h3) prime_reg <= prime_reg + 2'h1;
      session_valid_indicator_prev_reg <= session_valid_indicator_s;
      session_end_indicator_prev_reg <= session_end_indicator_s;
      if (line_s != line_prev_reg) begin
        stable_cnt_reg <= 32'h0; // see R19
        stable_reg <= 1'b0;
      end else if (stable_cnt_reg >= STABLE_CYC - 1) begin
        stable_reg <= 1'b1;
      end else begin
        stable_cnt_reg <= stable_cnt_reg + 32'h1;
      end
    end
  end
  // reset values of the pipeline are not the pin levels; avoids false edges
  wire primed = (prime_reg == 2'h3);
  wire session_valid_indicator_evt = primed & (session_valid_indicator_s ^ session_valid_indicator_prev_reg); // see R24
  wire session_end_indicator_evt = primed & session_end_indicator_s & ~session_end_indicator_prev_reg; // see R2
  // attach: se0 leaves to j; reset/detach: se0 begins
  wire attach_evt = primed & line_prev_reg[0] & ~line_s[0] & line_s[1];
  wire detach_evt = primed & ~line_prev_reg[0] & line_s[0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] otgcon_reg;
  reg [1:0] pwrc_reg;
  reg slpgrd_reg;
  reg [7:0] otgir_reg;
  reg [7:0] linkir_reg;
  reg pulse_reg;
  reg [7:0] bdtp_reg;
  reg [10:0] frame_reg;
  reg [7:0] ucon_reg;
  wire wr = psel_in & penable_in & pwrite_in;
  wire rd = psel_in & ~penable_in & ~pwrite_in;
  wire [7:0] wd = pwdata_in[7:0];
  wire [7:0] otgstat = {id_s, 1'b0, stable_reg, 1'b0, session_valid_indicator_s, session_end_indicator_s, 1'b0,
                        a_side_supply_valid_s}; // see R18 see R20
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      otgcon_reg <= 8'h00;
      pwrc_reg <= 2'h0;
      slpgrd_reg <= 1'b0;
      otgir_reg <= 8'h00;
      linkir_reg <= 8'h00;
      pulse_reg <= 1'b0;
      bdtp_reg <= 8'h00;
      frame_reg <= 11'h000;
      ucon_reg <= 8'h00;
    end else begin
      if (wr && paddr_in == `UOTG_OFF_OTGCON) otgcon_reg <= wd; // see R22
      if (wr && paddr_in == `UOTG_OFF_BDTP) bdtp_reg <= {wd[7:1], 1'b0}; // see R16
      if (wr && paddr_in == `UOTG_OFF_CNFG2) pulse_reg <= wd[`UOTG_BIT_PULSE]; // see R5
      if (wr && paddr_in == `UOTG_OFF_UCON) ucon_reg <= wd;
      if (wr && paddr_in == `UOTG_OFF_PWRC) begin
        pwrc_reg <= wd[1:0];
        slpgrd_reg <= wd[`UOTG_BIT_SLPGRD];
      end else if (activity_in) begin
        pwrc_reg[`UOTG_BIT_SUSP] <= 1'b0; // hardware leaves suspend on bus activity
      end
      if (frame_tick_in) frame_reg <= frame_reg + 11'h001; // see R17
      // write-one-to-clear; a same-cycle event wins
      otgir_reg <= (otgir_reg & ~((wr && paddr_in == `UOTG_OFF_OTGIR) ? wd : 8'h00))
                   | {4'h0, session_valid_indicator_evt, session_end_indicator_evt, 2'h0}; // see R2 see R24
      linkir_reg <= (linkir_reg & ~((wr && paddr_in == `UOTG_OFF_LINKIR) ? wd : 8'h00))
                    | {1'b0, attach_evt, 5'h00, detach_evt};
    end
  end

  // ----------------------------------------
  // apb read and outputs
  // ----------------------------------------
  reg [7:0] rmux;
  always @* begin
    case (paddr_in)
      `UOTG_OFF_OTGSTAT: rmux = otgstat;
      `UOTG_OFF_OTGCON: rmux = otgcon_reg;
      `UOTG_OFF_PWRC: rmux = {activity_in & slpgrd_reg, 2'h0, slpgrd_reg, 2'h0, pwrc_reg};
      `UOTG_OFF_OTGIR: rmux = otgir_reg;
      `UOTG_OFF_LINKIR: rmux = linkir_reg;
      `UOTG_OFF_CNFG2: rmux = {3'h0, pulse_reg, 4'h0};
      `UOTG_OFF_BDTP: rmux = bdtp_reg;
      `UOTG_OFF_FRML: rmux = frame_reg[7:0];
      `UOTG_OFF_FRMH: rmux = {5'h00, frame_reg[10:8]};
      `UOTG_OFF_UCON: rmux = ucon_reg;
      default: rmux = 8'h00;
    endcase
  end
  wire otg_on = otgcon_reg[`UOTG_BIT_DUAL_ROLE_FEATURES_ENABLE];
  wire host_on = ucon_reg[`UOTG_BIT_HOST_ROLE_ENABLE];
  wire dev_on = ucon_reg[`UOTG_BIT_PERIPHERAL_ROLE_ENABLE];
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      dplus_pullup_out <= 1'b0;
      dminus_pullup_out <= 1'b0;
      dplus_pulldown_out <= 1'b0;
      dminus_pulldown_out <= 1'b0;
      vbus_power_on_out <= 1'b0;
      vbus_charge_out <= 1'b0;
      vbus_discharge_out <= 1'b0;
      vbus_pulse_out <= 1'b0;
      clock_gate_out <= 1'b0;
      xcvr_low_power_out <= 1'b0;
      module_enable_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      if (rd) prdata_out <= {24'h0, rmux}; // see R15
      // software owns the pulls when dual-role enabled
      dplus_pullup_out <= otg_on ? otgcon_reg[`UOTG_BIT_DPPU] : (dev_on & ~host_on); // see R21
      dminus_pullup_out <= otg_on & otgcon_reg[`UOTG_BIT_DMPU]; // see R9 R21
      dplus_pulldown_out <= otg_on ? otgcon_reg[`UOTG_BIT_DPPD] : host_on; // see R21
      dminus_pulldown_out <= otg_on ? otgcon_reg[`UOTG_BIT_DMPD] : host_on; // see R21
      vbus_power_on_out <= otgcon_reg[`UOTG_BIT_VBON]; // see R22
      vbus_charge_out <= otgcon_reg[`UOTG_BIT_VBCHG]; // see R22
      vbus_discharge_out <= otgcon_reg[`UOTG_BIT_VBDIS]; // see R22
      vbus_pulse_out <= pulse_reg; // see R5
      clock_gate_out <= pwrc_reg[`UOTG_BIT_SUSP]; // see R23
      xcvr_low_power_out <= pwrc_reg[`UOTG_BIT_SUSP]; // see R23
      module_enable_out <= pwrc_reg[`UOTG_BIT_PWR]; // see R23
    end
  end
endmodule // uotg_session_ctrl

/* dv/uotg_checker_sva.sv */
// Purpose: port checker for the session control block
// Assumes: wait-free apb slave
// Notes: input age covers the synchroniser lag
`timescale 1ns/1ps
`include "uotg_consts.vh"
module uotg_checker #(
  parameter STABLE_CYC = `UOTG_STABLE_CYC
) (
  input wire clock_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`UOTG_ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire id_pin_in,
  input wire sess_vld_cmp_in,
  input wire sess_end_cmp_in,
  input wire vbus_vld_cmp_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire dplus_pullup_out,
  input wire vbus_power_on_out,
  input wire module_enable_out
);
  reg [3:0] in_prev_reg;
  reg [3:0] in_age_reg;
  wire [3:0] in_now = {id_pin_in, sess_vld_cmp_in, sess_end_cmp_in, vbus_vld_cmp_in};
  wire setup = psel_in && !penable_in;
  wire acc = psel_in && penable_in && pready_out;
  wire rd = acc && !pwrite_in;
  wire st_rd = rd && paddr_in == `UOTG_OFF_OTGSTAT && in_age_reg > 4'h6;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      in_prev_reg <= 4'h0;
      in_age_reg <= 4'h0;
    end else begin
      in_prev_reg <= in_now;
      in_age_reg <= (in_now != in_prev_reg) ? 4'h0 : in_age_reg + {3'h0, in_age_reg != 4'hF};
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_upper; rd |-> prdata_out[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_ready; pready_out == $past(setup); endproperty
  a_ready: assert property (p_ready) else $error("ready not after setup");
  property p_page; rd && paddr_in == `UOTG_OFF_BDTP |-> !prdata_out[0]; endproperty
  a_page: assert property (p_page) else $error("page bit0 set");
  property p_frame; rd && paddr_in == `UOTG_OFF_FRMH |-> prdata_out[7:3] == 5'h00; endproperty
  a_frame: assert property (p_frame) else $error("frame high too wide");
  property p_plug; st_rd |-> prdata_out[7] == id_pin_in; endproperty
  a_plug: assert property (p_plug) else $error("plug bit wrong");
  property p_vbus; st_rd |-> prdata_out[3:0] ==
    {sess_vld_cmp_in, sess_end_cmp_in, 1'b0, vbus_vld_cmp_in}; endproperty
  a_vbus: assert property (p_vbus) else $error("vbus status wrong");
  property p_ctrl; acc && pwrite_in && paddr_in == `UOTG_OFF_OTGCON && pwdata_in[2] |=> ##1
    dplus_pullup_out == $past(pwdata_in[7], 2) && vbus_power_on_out == $past(pwdata_in[3], 2);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("pull or power output wrong");
  property p_power; acc && pwrite_in && paddr_in == `UOTG_OFF_PWRC |=> ##1
    module_enable_out == $past(pwdata_in[0], 2); endproperty
  a_power: assert property (p_power) else $error("enable output wrong");
endmodule // uotg_checker
bind uotg_session_ctrl uotg_checker #(.STABLE_CYC(STABLE_CYC)) u_uotg_checker (
  .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .id_pin_in(id_pin_in),
  .sess_vld_cmp_in(sess_vld_cmp_in), .sess_end_cmp_in(sess_end_cmp_in),
  .vbus_vld_cmp_in(vbus_vld_cmp_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .dplus_pullup_out(dplus_pullup_out), .vbus_power_on_out(vbus_power_on_out),
  .module_enable_out(module_enable_out));

/* dv/uotg_peer_model.sv */
// Purpose: far-side dual-role device on the cable
// Assumes: vbus settles a few clocks after power turns on
// Notes: lines fall to se0 when no pull-up is on
`timescale 1ns/1ps
module uotg_peer_model #(
  parameter DLY = 3
) (
  input wire clock_in,
  input wire pullup_in,
  input wire vbus_on_in,
  output reg id_pin_out,
  output reg sess_vld_out,
  output reg sess_end_out,
  output reg vbus_vld_out,
  output reg se0_out,
  output reg jstate_out
);
  reg [7:0] vbus_hist_reg = 8'h00;
  // start with id high, vbus valid set, session end clear, lines at se0
  initial {id_pin_out, sess_vld_out, sess_end_out, vbus_vld_out, se0_out, jstate_out} = 6'h26;
  always @(posedge clock_in) begin
    vbus_hist_reg <= {vbus_hist_reg[6:0], vbus_on_in};
    sess_vld_out <= vbus_hist_reg[DLY];
    vbus_vld_out <= vbus_hist_reg[DLY];
    sess_end_out <= !vbus_hist_reg[DLY];
    se0_out <= !pullup_in;
    jstate_out <= pullup_in;
  end
endmodule // uotg_peer_model

/* dv/test_uotg_session_ctrl.sv */
// Purpose: register-level bench for the session control block
// Assumes: short line-stable count in sim
// Notes: far side answers vbus late
`timescale 1ns/1ps
`include "uotg_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_uotg_session_ctrl;
  reg clock_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  reg frame_tick_in = 0, activity_in = 0;
  reg [`UOTG_ADDR_W-1:0] paddr_in = 0;
  reg [31:0] pwdata_in = 0, rd_q;
  reg err_q = 0;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, dplus_pullup_out, dminus_pullup_out, dplus_pulldown_out;
  wire dminus_pulldown_out, vbus_power_on_out, vbus_charge_out, vbus_discharge_out;
  wire vbus_pulse_out, clock_gate_out, xcvr_low_power_out, module_enable_out;
  wire id_pin_in, sess_vld_cmp_in, sess_end_cmp_in, vbus_vld_cmp_in, se0_in, jstate_in;
  integer n_mismatch = 0, samples_checked = 0, i;
  always #4 clock_in = ~clock_in;
  uotg_session_ctrl #(.STABLE_CYC(20)) u_uotg_session_ctrl (.clock_in(clock_in),
    .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .id_pin_in(id_pin_in),
    .sess_vld_cmp_in(sess_vld_cmp_in), .sess_end_cmp_in(sess_end_cmp_in),
    .vbus_vld_cmp_in(vbus_vld_cmp_in), .se0_in(se0_in), .jstate_in(jstate_in),
    .frame_tick_in(frame_tick_in), .activity_in(activity_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .dplus_pullup_out(dplus_pullup_out),
    .dminus_pullup_out(dminus_pullup_out), .dplus_pulldown_out(dplus_pulldown_out),
    .dminus_pulldown_out(dminus_pulldown_out), .vbus_power_on_out(vbus_power_on_out),
    .vbus_charge_out(vbus_charge_out), .vbus_discharge_out(vbus_discharge_out),
    .vbus_pulse_out(vbus_pulse_out), .clock_gate_out(clock_gate_out),
    .xcvr_low_power_out(xcvr_low_power_out), .module_enable_out(module_enable_out));
  uotg_peer_model u_uotg_peer_model (.clock_in(clock_in),
    .pullup_in(dplus_pullup_out | dminus_pullup_out), .vbus_on_in(vbus_power_on_out),
    .id_pin_out(id_pin_in), .sess_vld_out(sess_vld_cmp_in), .sess_end_out(sess_end_cmp_in),
    .vbus_vld_out(vbus_vld_cmp_in), .se0_out(se0_in), .jstate_out(jstate_in));
  task apb(input w, input [`UOTG_ADDR_W-1:0] a, input [31:0] d);
    begin
      @(posedge clock_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1;
      // no fixed wait: only the watchdog ends a hung transfer
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd_q = prdata_out;
      err_q = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
    end
  endtask
  task chk(input [`UOTG_ADDR_W-1:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h00000000);
      `CHK({err_q, rd_q}, {1'b0, e})
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 0;
    chk(`UOTG_OFF_OTGCON, 32'h00000000);
    chk(6'h3C, 32'h00000000);
    apb(1, `UOTG_OFF_OTGCON, 32'hFFFFFFAC);
    chk(`UOTG_OFF_OTGCON, 32'h000000AC);
    `CHK({dplus_pullup_out, dminus_pullup_out, dplus_pulldown_out, dminus_pulldown_out,
      vbus_power_on_out, vbus_charge_out, vbus_discharge_out}, 7'h54)
    repeat (40) @(posedge clock_in);
    chk(`UOTG_OFF_OTGSTAT, 32'h000000A9);
    apb(1, `UOTG_OFF_OTGIR, 32'h000000FF);
    apb(1, `UOTG_OFF_OTGCON, 32'h00000004);
    repeat (12) @(posedge clock_in);
    chk(`UOTG_OFF_OTGSTAT, 32'h00000084);
    chk(`UOTG_OFF_OTGIR, 32'h0000000C);
    apb(1, `UOTG_OFF_OTGCON, 32'h00000000);
    apb(1, `UOTG_OFF_UCON, 32'h00000008);
    repeat (2) @(posedge clock_in);
    `CHK({dplus_pullup_out, dplus_pulldown_out, dminus_pulldown_out}, 3'h3)
    apb(1, `UOTG_OFF_BDTP, 32'hFFFFFFFF);
    chk(`UOTG_OFF_BDTP, 32'h000000FE);
    apb(1, `UOTG_OFF_PWRC, 32'h00000001);
    for (i = 0; i < 261; i = i + 1) begin
      @(posedge clock_in) frame_tick_in <= 1;
      @(posedge clock_in) frame_tick_in <= 0;
    end
    chk(`UOTG_OFF_FRML, 32'h00000005);
    chk(`UOTG_OFF_FRMH, 32'h00000001);
    apb(1, `UOTG_OFF_PWRC, 32'h00000013);
    repeat (2) @(posedge clock_in);
    `CHK({clock_gate_out, xcvr_low_power_out, module_enable_out}, 3'h7)
    activity_in <= 1;
    repeat (4) @(posedge clock_in);
    chk(`UOTG_OFF_PWRC, 32'h00000091);
    apb(1, `UOTG_OFF_OTGIR, 32'h000000FF);
    apb(1, `UOTG_OFF_LINKIR, 32'h000000FF);
    chk(`UOTG_OFF_OTGSTAT, 32'h000000A4);
    apb(1, `UOTG_OFF_OTGCON, 32'h00000084);
    repeat (8) @(posedge clock_in);
    apb(1, `UOTG_OFF_OTGCON, 32'h00000004);
    repeat (8) @(posedge clock_in);
    chk(`UOTG_OFF_LINKIR, 32'h00000041);
    apb(1, `UOTG_OFF_CNFG2, 32'hFFFFFFFF);
    chk(`UOTG_OFF_CNFG2, 32'h00000010);
    `CHK(vbus_pulse_out, 1'b1)
    apb(1, `UOTG_OFF_CNFG2, 32'h00000000);
    apb(1, `UOTG_OFF_OTGCON, 32'h0000000E);
    repeat (12) @(posedge clock_in);
    chk(`UOTG_OFF_OTGIR, 32'h00000008);
    `CHK({vbus_pulse_out, vbus_power_on_out, vbus_charge_out}, 3'h3)
    apb(1, `UOTG_OFF_OTGCON, 32'h0000004D);
    repeat (8) @(posedge clock_in);
    `CHK({dplus_pullup_out, dminus_pullup_out, vbus_discharge_out}, 3'h3)
    apb(1, `UOTG_OFF_LINKIR, 32'h000000FF);
    apb(1, `UOTG_OFF_OTGCON, 32'h00000004);
    repeat (8) @(posedge clock_in);
    apb(1, `UOTG_OFF_OTGCON, 32'h00000084);
    repeat (8) @(posedge clock_in);
    chk(`UOTG_OFF_LINKIR, 32'h00000041);
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge clock_in);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // test_uotg_session_ctrl
